// ==== design/bwgp_pkg.sv ====
package bwgp_pkg;

	// Port width and register byte addresses on the APB word map
	localparam int PIN_COUNT = 8;
	localparam logic [11:0] ADDR_FUNC_SEL = 12'h000;
	localparam logic [11:0] ADDR_DIRECTION = 12'h004;
	localparam logic [11:0] ADDR_PIN_LEVEL = 12'h008;
	localparam logic [11:0] ADDR_OUT_VALUE = 12'h00c;
	localparam logic [11:0] ADDR_PULLUP = 12'h010;

	// Values after reset
	localparam logic [7:0] FUNC_SEL_RESET = 8'h00;
	localparam logic [7:0] DIRECTION_RESET = 8'h00;
	localparam logic [7:0] PULLUP_RESET = 8'h00;

	// Synchroniser depth on pin levels
	localparam int SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		BWGP_REG_FUNC,
		BWGP_REG_DIR,
		BWGP_REG_LEVEL,
		BWGP_REG_OUT,
		BWGP_REG_PULL,
		BWGP_REG_NONE
	} bwgp_reg_type;

endpackage

// ==== design/bwgp_port.sv ====
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module bwgp_port #(
	parameter int WIDTH = 8,
	parameter bit HAS_ALT = 1'b1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] pin_o,
	output logic [WIDTH-1:0] pin_oe,
	output logic [WIDTH-1:0] pin_pullup_en,
	output logic [WIDTH-1:0] pin_input_en,
	input wire logic [WIDTH-1:0] periph_out,
	input wire logic [WIDTH-1:0] periph_oe,
	input wire logic [WIDTH-1:0] periph_in_need,
	output logic [WIDTH-1:0] periph_in
);

	logic [WIDTH-1:0] func_q, func_d;
	logic [WIDTH-1:0] dir_q, dir_d;
	logic [WIDTH-1:0] pull_q, pull_d;
	logic [WIDTH-1:0] outv_q, outv_d;
	logic [WIDTH-1:0] sync1_q, sync2_q;
	logic [31:0] prdata_q, prdata_d;
	logic pslverr_q, pslverr_d;
	logic wr_en, rd_en, setup_rd;
	bwgp_pkg::bwgp_reg_type sel;

	// Address decode, used for reads, writes and input gating
	function automatic bwgp_pkg::bwgp_reg_type decode(input logic [11:0] a,
		input bit alt);
		if (a == bwgp_pkg::ADDR_FUNC_SEL && alt)
			return bwgp_pkg::BWGP_REG_FUNC;
		else if (a == bwgp_pkg::ADDR_DIRECTION)
			return bwgp_pkg::BWGP_REG_DIR;
		else if (a == bwgp_pkg::ADDR_PIN_LEVEL)
			return bwgp_pkg::BWGP_REG_LEVEL;
		else if (a == bwgp_pkg::ADDR_OUT_VALUE)
			return bwgp_pkg::BWGP_REG_OUT;
		else if (a == bwgp_pkg::ADDR_PULLUP)
			return bwgp_pkg::BWGP_REG_PULL;
		else
			return bwgp_pkg::BWGP_REG_NONE;
	endfunction

	assign sel = decode(paddr, HAS_ALT);
	assign wr_en = psel && penable && pwrite && pstrb[0];
	assign rd_en = psel && penable && !pwrite;
	assign setup_rd = psel && !penable && !pwrite
		&& sel == bwgp_pkg::BWGP_REG_LEVEL;
	// Zero wait states
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	always_comb
	begin
		func_d = func_q;
		dir_d = dir_q;
		pull_d = pull_q;
		outv_d = outv_q;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		if (psel && !penable)
		begin
			pslverr_d = (sel == bwgp_pkg::BWGP_REG_NONE)
				|| (pwrite && sel == bwgp_pkg::BWGP_REG_LEVEL);
			prdata_d = 32'h0000_0000;
			unique case (sel)
				bwgp_pkg::BWGP_REG_FUNC: prdata_d[WIDTH-1:0] = func_q;
				bwgp_pkg::BWGP_REG_DIR: prdata_d[WIDTH-1:0] = dir_q;
				bwgp_pkg::BWGP_REG_LEVEL: prdata_d[WIDTH-1:0] = sync2_q;
				bwgp_pkg::BWGP_REG_OUT: prdata_d[WIDTH-1:0] = outv_q;
				bwgp_pkg::BWGP_REG_PULL: prdata_d[WIDTH-1:0] = pull_q;
				bwgp_pkg::BWGP_REG_NONE: prdata_d = 32'h0000_0000;
			endcase
		end
		if (wr_en)
		begin
			unique case (sel)
				bwgp_pkg::BWGP_REG_FUNC: func_d = pwdata[WIDTH-1:0];
				bwgp_pkg::BWGP_REG_DIR: dir_d = pwdata[WIDTH-1:0];
				bwgp_pkg::BWGP_REG_OUT: outv_d = pwdata[WIDTH-1:0];
				bwgp_pkg::BWGP_REG_PULL: pull_d = pwdata[WIDTH-1:0];
				bwgp_pkg::BWGP_REG_LEVEL,
				bwgp_pkg::BWGP_REG_NONE: pslverr_d = pslverr_q;
			endcase
		end
		if (rd_en)
			pslverr_d = pslverr_q;
		if (wr_en)
			pslverr_d = pslverr_q;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			func_q <= WIDTH'(bwgp_pkg::FUNC_SEL_RESET);
			dir_q <= WIDTH'(bwgp_pkg::DIRECTION_RESET);
			pull_q <= WIDTH'(bwgp_pkg::PULLUP_RESET);
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else
		begin
			func_q <= HAS_ALT ? func_d : '0;
			dir_q <= dir_d;
			pull_q <= pull_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	// output value keeps its contents over reset
	always_ff @(posedge clk)
	begin
		outv_q <= outv_d;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_pin
			assign pin_o[i] = func_q[i] ? periph_out[i] : outv_q[i];
			assign pin_oe[i] = func_q[i] ? periph_oe[i] : dir_q[i];
			assign pin_pullup_en[i] = pull_q[i] && !func_q[i] && !dir_q[i];
			assign pin_input_en[i] = func_q[i] ? 1'b1
				: (setup_rd || periph_in_need[i]);
			assign periph_in[i] = func_q[i] ? sync2_q[i] : 1'b0;
		end
	endgenerate

endmodule

// ==== sim/bwgp_pad.sv ====
`timescale 1ns/10ps
module bwgp_pad (
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup_en,
	input wire logic [7:0] ext_v,
	input wire logic [7:0] ext_en,
	output logic [7:0] pin_i
);
	logic t = 1'b0;
	always #25 t = ~t;
	// Drive, outside source, pull-up, else moving
	assign pin_i = pin_oe & pin_o | ~pin_oe & (ext_en & ext_v |
		~ext_en & (pin_pullup_en | {8{t}}));
endmodule

// ==== sim/bwgp_port_checker.sv ====
`timescale 1ns/10ps
module bwgp_port_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pslverr,
	input wire logic [7:0] pin_i,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup_en,
	input wire logic [7:0] pin_input_en,
	input wire logic [7:0] periph_in
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_a; psel && penable; endsequence
	property p_rst; $fell(sys_rst) |-> !(pin_oe | pin_pullup_en); endproperty
	property p_ro; s_a ##0 pwrite && paddr == 12'h008 |-> pslverr; endproperty
	property p_um; s_a ##0 paddr > 12'h010 |-> pslverr; endproperty
	property p_ok; s_a ##0 paddr == 12'h004 |-> !pslverr; endproperty
	property p_pu; !(pin_pullup_en & pin_oe); endproperty
	property p_ie; !(periph_in & ~pin_input_en); endproperty
	property p_sy; !(periph_in & ~$past(pin_i, 2)); endproperty
	property p_pr; $rose(|pin_pullup_en) |-> $past(pwrite); endproperty
	a_rst: assert property (p_rst) else $error("rst");
	a_ro: assert property (p_ro) else $error("ro");
	a_um: assert property (p_um) else $error("um");
	a_ok: assert property (p_ok) else $error("ok");
	a_pu: assert property (p_pu) else $error("pu");
	a_ie: assert property (p_ie) else $error("ie");
	a_sy: assert property (p_sy) else $error("sy");
	a_pr: assert property (p_pr) else $error("pr");
endmodule

// ==== sim/bwgp_port_test.sv ====
`timescale 1ns/10ps
bind bwgp_port bwgp_port_checker bwgp_port_checker_i (.*);
module bwgp_port_test;
	logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] pin_i, pin_o, pin_oe, pin_pullup_en, pin_input_en, periph_in;
	logic [7:0] periph_out = 8'h00, periph_oe = 8'h00, ext_v, ext_en;
	int err_total = 0, check_count = 0;
	always #12.5 clk = ~clk;
	bwgp_port bwgp_port_i (.*, .pstrb(4'hf), .periph_in_need(8'h00));
	bwgp_pad bwgp_pad_i (.*);
	task automatic chk(input string s, input logic [31:0] g, e);
		check_count++;
		err_total += int'(g !== e);
		if (g !== e)
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
	endtask
	task automatic summarize(input int t);
		err_total += t;
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Write data or expected read data in v
	task automatic x(input logic w, input logic [11:0] a,
		input logic [7:0] v, input logic r = 1'b0);
		int n;
		repeat (3) @(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, v};
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n == 0 || pready !== 1'b1; n++)
			if (n < 9)
				@(posedge clk);
			else
				summarize(1);
		if (!w)
			chk("prdata", prdata, {24'h0, v});
		chk("pslverr", pslverr, r);
		{psel, penable} <= 2'h0;
	endtask
	initial
	begin
		{pwrite, paddr, pwdata, ext_v, ext_en} <= '0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		x(1'b0, 12'h000, 8'h00);
		x(1'b0, 12'h004, 8'h00);
		x(1'b0, 12'h010, 8'h00);
		{ext_en, ext_v} <= 16'hf050;
		x(1'b1, 12'h00c, 8'ha5);
		x(1'b1, 12'h004, 8'h0f);
		x(1'b0, 12'h00c, 8'ha5);
		x(1'b0, 12'h008, 8'h55);
		{ext_en, ext_v} <= 16'h3000;
		x(1'b1, 12'h010, 8'hff);
		@(negedge clk);
		chk("pullup", pin_pullup_en, 8'hf0);
		chk("input_en", pin_input_en, 8'h00);
		x(1'b0, 12'h008, 8'hc5);
		x(1'b1, 12'h00c, 8'h00);
		x(1'b0, 12'h008, 8'hc0);
		x(1'b1, 12'h004, 8'h00);
		x(1'b0, 12'h008, 8'hcf);
		x(1'b1, 12'h008, 8'h5a, 1'b1);
		x(1'b1, 12'h014, 8'h5a, 1'b1);
		x(1'b1, 12'h000, 8'hff);
		{periph_out, periph_oe, ext_en, ext_v} <= 32'h3c0ff0a0;
		x(1'b0, 12'h008, 8'hac);
		chk("periph_in", periph_in, 8'hac);
		chk("pullup", pin_pullup_en, 8'h00);
		chk("pin_o", pin_o, 8'h3c);
		chk("pin_oe", pin_oe, 8'h0f);
		chk("input_en", pin_input_en, 8'hff);
		x(1'b1, 12'h00c, 8'h96);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		x(1'b0, 12'h00c, 8'h96);
		x(1'b0, 12'h000, 8'h00);
		@(negedge clk);
		chk("pin_oe", pin_oe, 8'h00);
		summarize(0);
	end
endmodule
